// *** ssl_pkg.sv ***
// Package for the synthesizer serial latch bank: addresses, field layout, reset values
package ssl_pkg;
  localparam int WORD_W = 24;

  // Latch select codes, held as {addr_bit_hi, addr_bit_lo}
  localparam logic [1:0] ADDR_CFG = 2'h0;
  localparam logic [1:0] ADDR_REF = 2'h1;
  localparam logic [1:0] ADDR_FB = 2'h2;

  // config_word fields
  localparam int CFG_PRESC_LSB = 22;
  localparam int CFG_PD_SYNC = 21;
  localparam int CFG_PD_REQ = 20;
  localparam int CFG_SET2_LSB = 17;
  localparam int CFG_SET1_LSB = 14;
  localparam int CFG_MUTE = 11;
  localparam int CFG_GAIN = 10;
  localparam int CFG_TRI = 9;
  localparam int CFG_POL = 8;
  localparam int CFG_CLR = 4;

  // feedback_divider_word fields
  localparam int FB_SEL = 23;
  localparam int FB_HALVE = 22;
  localparam int FB_GAIN = 21;
  localparam int FB_MAIN_LSB = 8;
  localparam int FB_SWAL_LSB = 2;

  // reference_divider_word fields
  localparam int REF_BAND_LSB = 20;
  localparam int REF_TEST = 19;
  localparam int REF_LOCK = 18;
  localparam int REF_BACK_LSB = 16;
  localparam int REF_RATIO_LSB = 2;

  localparam logic [23:0] CFG_RST = 24'h00_0000;
  localparam logic [23:0] FB_RST = 24'h00_0000;
  localparam logic [23:0] REF_RST = 24'h00_0000;
  localparam logic GAIN_RST = 1'h0;

  localparam logic [12:0] MAIN_MIN = 13'h0003;
  localparam logic [13:0] REF_MIN = 14'h0001;
  localparam logic [2:0] LOCK_SHORT = 3'h3;
  localparam logic [2:0] LOCK_LONG = 3'h5;
  localparam logic [1:0] PD_REF_EDGES = 2'h2;

  typedef enum logic [1:0] {PD_RUN, PD_ARMED, PD_DOWN} ssl_pd_t;
endpackage

// *** ssl_word_if.sv ***
// Interface carrying a completed serial word and its load pulse
`timescale 1ns/1ps
interface ssl_word_if;
  logic [23:0] word;
  logic load;
  modport src (output word, output load);
  modport dst (input word, input load);
endinterface

// *** ssl_shifter.sv ***
// Serial input register: shifts on serial clock rise, hands over on strobe rise
`timescale 1ns/1ps
module ssl_shifter (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  ssl_word_if.src wb
);
  logic sclk_q;
  logic le_q;
  logic [23:0] shift;
  logic sclk_rise;
  logic le_rise;
  logic [23:0] next_shift;

  assign sclk_rise = ser_clk & ~sclk_q;
  assign le_rise = load_strobe & ~le_q;
  // First bit in ends up in bit 23
  assign next_shift = {shift[22:0], ser_data};

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sclk_q <= 1'h0;
      le_q <= 1'h0;
      shift <= ssl_pkg::CFG_RST;
      wb.word <= ssl_pkg::CFG_RST;
      wb.load <= 1'h0;
    end
    else
    begin
      sclk_q <= ser_clk;
      le_q <= load_strobe;
      if (sclk_rise)
        shift <= next_shift;
      wb.load <= le_rise;
      if (le_rise)
        wb.word <= shift;
    end
  end

  shift_in_a: assert property (@(posedge clk) disable iff (!nrst)
    sclk_rise && !le_rise |=> shift[0] == $past(ser_data) && shift[23:1] == $past(shift[22:0]))
    else $error("serial bit not shifted in");
  hand_over_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(load_strobe) |=> wb.load ##1 !wb.load)
    else $error("strobe rise did not give one load pulse");
endmodule

// *** ssl_latch_bank.sv ***
// Three-wire programmed latch bank with reference divider, lock count and power-down
`timescale 1ns/1ps
module ssl_latch_bank #(
  parameter int PRESC_BASE = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic ref_in,
  input wire logic phase_ok,
  output logic [2:0] pump_current,
  output logic pump_hiz,
  output logic pfd_positive,
  output logic counters_held,
  output logic rf_out_en,
  output logic halve_en,
  output logic prescaler_halved,
  output logic [4:0] swallow_count,
  output logic [12:0] main_count,
  output logic main_count_bad,
  output logic [13:0] ref_ratio,
  output logic ref_ratio_bad,
  output logic [20:0] fb_total,
  output logic [1:0] backlash_width,
  output logic ref_tick,
  output logic band_clk,
  output logic locked,
  output logic powered_down
);
  ssl_word_if wb ();

  ssl_shifter u_shifter (
    .clk(clk),
    .nrst(nrst),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .load_strobe(load_strobe),
    .wb(wb)
  );

  logic [23:0] config_word;
  logic [23:0] feedback_divider_word;
  logic [23:0] reference_divider_word;
  logic pump_gain_sel;

  logic [1:0] addr;
  logic load_cfg;
  logic load_fb;
  logic load_ref;

  assign addr = wb.word[1:0];
  assign load_cfg = wb.load && addr == ssl_pkg::ADDR_CFG;
  assign load_fb = wb.load && addr == ssl_pkg::ADDR_FB;
  assign load_ref = wb.load && addr == ssl_pkg::ADDR_REF;
  // Code 11 addresses the factory test latch, which this block never stores

  // Each latch takes only words carrying its own address
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      config_word <= ssl_pkg::CFG_RST;
      feedback_divider_word <= ssl_pkg::FB_RST;
      reference_divider_word <= ssl_pkg::REF_RST;
      pump_gain_sel <= ssl_pkg::GAIN_RST;
    end
    else
    begin
      if (load_cfg)
        config_word <= wb.word;
      if (load_fb)
        feedback_divider_word <= wb.word;
      if (load_ref)
        reference_divider_word <= wb.word;
      if (load_cfg)
        pump_gain_sel <= wb.word[ssl_pkg::CFG_GAIN];
      else if (load_fb)
        pump_gain_sel <= wb.word[ssl_pkg::FB_GAIN];
    end
  end

  // Field decode
  logic [1:0] presc_code;
  logic [2:0] pump_set1;
  logic [2:0] pump_set2;
  logic mute_until_lock;
  logic pump_tristate;
  logic phase_polarity;
  logic counters_clear;
  logic [4:0] swallow;
  logic [12:0] main_div;
  logic [13:0] ratio;
  logic [1:0] band_clk_div;
  logic lock_count_sel;
  logic factory_test_en;

  assign presc_code = config_word[ssl_pkg::CFG_PRESC_LSB +: 2];
  assign pump_set1 = config_word[ssl_pkg::CFG_SET1_LSB +: 3];
  assign pump_set2 = config_word[ssl_pkg::CFG_SET2_LSB +: 3];
  assign mute_until_lock = config_word[ssl_pkg::CFG_MUTE];
  assign pump_tristate = config_word[ssl_pkg::CFG_TRI];
  assign phase_polarity = config_word[ssl_pkg::CFG_POL];
  assign counters_clear = config_word[ssl_pkg::CFG_CLR];
  assign swallow = feedback_divider_word[ssl_pkg::FB_SWAL_LSB +: 5];
  assign main_div = feedback_divider_word[ssl_pkg::FB_MAIN_LSB +: 13];
  assign ratio = reference_divider_word[ssl_pkg::REF_RATIO_LSB +: 14];
  assign band_clk_div = reference_divider_word[ssl_pkg::REF_BAND_LSB +: 2];
  assign lock_count_sel = reference_divider_word[ssl_pkg::REF_LOCK];
  // Test latch contents are never applied; the bit is kept only for visibility
  assign factory_test_en = reference_divider_word[ssl_pkg::REF_TEST];

  // Power-down sequencing
  ssl_pkg::ssl_pd_t pd;
  ssl_pkg::ssl_pd_t next_pd;
  logic [1:0] pd_edges;
  logic [1:0] next_pd_edges;
  logic hold;

  assign hold = counters_clear || pd == ssl_pkg::PD_DOWN;

  always_comb
  begin
    next_pd = pd;
    next_pd_edges = pd_edges;
    if (load_cfg)
    begin
      if (!wb.word[ssl_pkg::CFG_PD_REQ])
        next_pd = ssl_pkg::PD_RUN;
      else if (!wb.word[ssl_pkg::CFG_PD_SYNC])
        next_pd = ssl_pkg::PD_DOWN;
      else if (pd != ssl_pkg::PD_DOWN)
      begin
        next_pd = ssl_pkg::PD_ARMED;
        next_pd_edges = 2'h0;
      end
    end
    else
    begin
      case (pd)
        ssl_pkg::PD_ARMED:
          if (ref_tick)
          begin
            if (pd_edges == ssl_pkg::PD_REF_EDGES - 2'h1)
              next_pd = ssl_pkg::PD_DOWN;
            else
              next_pd_edges = pd_edges + 2'h1;
          end
        ssl_pkg::PD_RUN,
        ssl_pkg::PD_DOWN:
          next_pd = pd;
        default:
          next_pd = ssl_pkg::PD_RUN;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pd <= ssl_pkg::PD_RUN;
      pd_edges <= 2'h0;
    end
    else
    begin
      pd <= next_pd;
      pd_edges <= next_pd_edges;
    end
  end

  // Reference counter: counts reference input rises, ticks every ratio of them
  logic ref_q;
  logic ref_edge;
  logic [13:0] rcnt;
  logic r_wrap;

  assign ref_edge = ref_in & ~ref_q;
  // A ratio of zero is not valid; it behaves as one rather than stalling
  assign r_wrap = ({1'b0, rcnt} + 15'h0001) >= {1'b0, ratio};

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ref_q <= 1'h0;
      rcnt <= 14'h0000;
      ref_tick <= 1'h0;
    end
    else
    begin
      ref_q <= ref_in;
      ref_tick <= !hold && ref_edge && r_wrap;
      if (hold)
        rcnt <= 14'h0000;
      else if (ref_edge)
        rcnt <= r_wrap ? 14'h0000 : rcnt + 14'h0001;
    end
  end

  // Band-select clock: reference ticks divided by 1, 2, 4 or 8
  logic [2:0] bcnt;
  logic [2:0] band_mask;
  logic band_fire;

  assign band_mask = 3'((4'h1 << band_clk_div) - 4'h1);
  assign band_fire = ref_tick && (bcnt & band_mask) == band_mask;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bcnt <= 3'h0;
      band_clk <= 1'h0;
    end
    else
    begin
      band_clk <= band_fire;
      if (hold)
        bcnt <= 3'h0;
      else if (ref_tick)
        bcnt <= bcnt + 3'h1;
    end
  end

  // Lock detect: phase_ok sampled once per reference tick, consecutive count
  logic [2:0] lcnt;
  logic [2:0] lock_need;
  logic [2:0] next_lcnt;

  assign lock_need = lock_count_sel ? ssl_pkg::LOCK_LONG : ssl_pkg::LOCK_SHORT;
  assign next_lcnt = hold ? 3'h0
    : !ref_tick ? lcnt
    : !phase_ok ? 3'h0
    : (lcnt >= lock_need) ? lcnt : lcnt + 3'h1;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      lcnt <= 3'h0;
      locked <= 1'h0;
    end
    else
    begin
      lcnt <= next_lcnt;
      locked <= next_lcnt >= lock_need;
    end
  end

  // Output decode, all registered
  logic [6:0] presc_mod;
  logic [20:0] next_fb_total;

  assign presc_mod = 7'(PRESC_BASE << presc_code);
  assign next_fb_total = 21'(presc_mod * main_div) + 21'(swallow);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pump_current <= 3'h0;
      pump_hiz <= 1'h1;
      pfd_positive <= 1'h0;
      counters_held <= 1'h0;
      rf_out_en <= 1'h0;
      halve_en <= 1'h0;
      prescaler_halved <= 1'h0;
      swallow_count <= 5'h00;
      main_count <= 13'h0000;
      main_count_bad <= 1'h1;
      ref_ratio <= 14'h0000;
      ref_ratio_bad <= 1'h1;
      fb_total <= 21'h00_0000;
      backlash_width <= 2'h0;
      powered_down <= 1'h0;
    end
    else
    begin
      pump_current <= pump_gain_sel ? pump_set2 : pump_set1;
      // Power-down also floats the pump
      pump_hiz <= pump_tristate || pd == ssl_pkg::PD_DOWN;
      pfd_positive <= phase_polarity;
      counters_held <= hold;
      rf_out_en <= pd != ssl_pkg::PD_DOWN && (!mute_until_lock || locked);
      halve_en <= feedback_divider_word[ssl_pkg::FB_HALVE];
      prescaler_halved <= feedback_divider_word[ssl_pkg::FB_SEL];
      swallow_count <= swallow;
      main_count <= main_div;
      main_count_bad <= main_div < ssl_pkg::MAIN_MIN;
      ref_ratio <= ratio;
      ref_ratio_bad <= ratio < ssl_pkg::REF_MIN;
      fb_total <= next_fb_total;
      backlash_width <= reference_divider_word[ssl_pkg::REF_BACK_LSB +: 2];
      powered_down <= pd == ssl_pkg::PD_DOWN;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence fb_load_s;
    load_fb;
  endsequence
  sequence pd_async_s;
    load_cfg && wb.word[ssl_pkg::CFG_PD_REQ] && !wb.word[ssl_pkg::CFG_PD_SYNC];
  endsequence
  sequence pd_last_edge_s;
    pd == ssl_pkg::PD_ARMED && ref_tick && pd_edges == 2'h1 && !load_cfg;
  endsequence

  route_fb_a: assert property (fb_load_s |=> ##1
    main_count == $past(wb.word[ssl_pkg::FB_MAIN_LSB +: 13], 2))
    else $error("feedback word not routed to main count");
  route_ref_a: assert property (load_ref |=> ##1
    ref_ratio == $past(wb.word[ssl_pkg::REF_RATIO_LSB +: 14], 2))
    else $error("reference word not routed to ratio");
  route_cfg_a: assert property (load_cfg |=> ##1
    pfd_positive == $past(wb.word[ssl_pkg::CFG_POL], 2))
    else $error("config word not routed to polarity");
  gain_latest_a: assert property (fb_load_s |=> ##1
    pump_current == ($past(wb.word[ssl_pkg::FB_GAIN], 2) ? pump_set2 : pump_set1))
    else $error("latest gain write not applied");
  mute_hold_a: assert property (mute_until_lock && !locked |=> !rf_out_en)
    else $error("RF enabled before lock while muted");
  tristate_a: assert property (pump_tristate |=> pump_hiz)
    else $error("pump not floated");
  clear_hold_a: assert property (counters_clear |=> rcnt == 14'h0000 && !ref_tick)
    else $error("counters run while cleared");
  lock_drop_a: assert property (ref_tick && !phase_ok |=> !locked)
    else $error("lock held after bad phase cycle");
  band_div1_a: assert property (ref_tick && band_clk_div == 2'h0 |=> band_clk)
    else $error("undivided band clock missed a tick");
  pd_async_a: assert property (pd_async_s |=> ##1 powered_down)
    else $error("asynchronous power-down late");
  pd_sync_a: assert property (pd_last_edge_s |=> ##1 powered_down)
    else $error("synchronous power-down not on second tick");
  latch_keep_a: assert property (load_cfg |=>
    $stable(feedback_divider_word) && $stable(reference_divider_word))
    else $error("other latch changed on config load");
endmodule

// *** ssl_host.sv ***
// Host-side model of the three-wire programming port
`timescale 1ns/1ps
module ssl_host (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe
);
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end

  // Low 3 clocks and high 2 keeps the serial clock at 20 MHz; slow stretches the low phase
  task automatic send(input logic [23:0] w, input int slow);
    logic [23:0] v;
    v = w;
    v[7] = v[7] & (v[1:0] != ssl_pkg::ADDR_FB);
    v[19] = v[19] & (v[1:0] != ssl_pkg::ADDR_REF);
    @(posedge clk);
    load_strobe <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      ser_clk <= 1'b0;
      ser_data <= v[i];
      repeat (3 + slow) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (2) @(posedge clk);
    end
    // Serial clock stands low between frames; data line no longer holds the last bit
    ser_clk <= 1'b0;
    ser_data <= ~v[0];
    repeat (2) @(posedge clk);
    load_strobe <= 1'b1;
    repeat (3) @(posedge clk);
    load_strobe <= 1'b0;
  endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the serial latch bank
`timescale 1ns/1ps
module tb;
  localparam int PB = 8;
  logic clk, nrst, ref_in, phase_ok, ref_run;
  logic ser_clk, ser_data, load_strobe;
  logic [2:0] pump_current;
  logic pump_hiz, pfd_positive, counters_held, rf_out_en, halve_en, prescaler_halved;
  logic [4:0] swallow_count;
  logic [12:0] main_count;
  logic [13:0] ref_ratio;
  logic [20:0] fb_total;
  logic [1:0] backlash_width, rdiv;
  logic main_count_bad, ref_ratio_bad, ref_tick, band_clk, locked, powered_down;
  logic [23:0] cur_cfg, cur_fb, cur_ref;
  logic cur_gain, exp_lock;
  int seed, fails, checks_done, cycles, ticks, bands;
  logic [23:0] corners [8] = '{24'h00_0002, 24'h00_0202, 24'hff_ff7e, 24'hcf_fbfc,
    24'h00_0001, 24'h03_fffd, 24'h20_0302, 24'h00_0005};

  ssl_host host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));

  ssl_latch_bank #(.PRESC_BASE(PB)) dut (
    .clk(clk), .nrst(nrst), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_strobe(load_strobe), .ref_in(ref_in), .phase_ok(phase_ok),
    .pump_current(pump_current), .pump_hiz(pump_hiz), .pfd_positive(pfd_positive),
    .counters_held(counters_held), .rf_out_en(rf_out_en), .halve_en(halve_en),
    .prescaler_halved(prescaler_halved), .swallow_count(swallow_count),
    .main_count(main_count), .main_count_bad(main_count_bad), .ref_ratio(ref_ratio),
    .ref_ratio_bad(ref_ratio_bad), .fb_total(fb_total), .backlash_width(backlash_width),
    .ref_tick(ref_tick), .band_clk(band_clk), .locked(locked), .powered_down(powered_down));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reference input at a quarter of the clock rate, stoppable to pin down tick timing
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (ref_run)
    begin
      rdiv <= rdiv + 2'h1;
      ref_in <= rdiv[1];
    end
    if (cycles == 30000)
    begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_tick();
    for (int k = 0; k < 300; k++)
    begin
      settle(1);
      if (ref_tick === 1'b1)
        return;
    end
    fails++;
  endtask

  function automatic logic [20:0] exp_total(input logic [23:0] c, input logic [23:0] f);
    return 21'((PB << c[23:22]) * f[20:8] + f[6:2]);
  endfunction

  // Power-down stays out of random control words; feedback bit 7 and the reference test bit go out as zero
  function automatic logic [23:0] fix(input logic [23:0] v);
    logic [23:0] x;
    x = v;
    x[7] = x[7] & (x[1:0] != ssl_pkg::ADDR_FB);
    x[19] = x[19] & (x[1:0] != ssl_pkg::ADDR_REF);
    if (x[1:0] == ssl_pkg::ADDR_CFG)
      x[21:20] = 2'h0;
    return x;
  endfunction

  task automatic put(input logic [23:0] v, input int slow);
    host.send(v, slow);
    case (v[1:0])
      ssl_pkg::ADDR_CFG: {cur_cfg, cur_gain} = {v, v[10]};
      ssl_pkg::ADDR_FB: {cur_fb, cur_gain} = {v, v[21]};
      ssl_pkg::ADDR_REF: cur_ref = v;
      default: cur_gain = cur_gain;
    endcase
    settle(3);
  endtask

  task automatic check_all();
    cmp(pump_current, cur_gain ? cur_cfg[19:17] : cur_cfg[16:14]);
    cmp(pump_hiz, cur_cfg[9]);
    cmp(pfd_positive, cur_cfg[8]);
    cmp(counters_held, cur_cfg[4]);
    cmp(rf_out_en, !cur_cfg[11] || exp_lock);
    cmp(halve_en, cur_fb[22]);
    cmp(prescaler_halved, cur_fb[23]);
    cmp(swallow_count, cur_fb[6:2]);
    cmp(main_count, cur_fb[20:8]);
    cmp(main_count_bad, cur_fb[20:8] < 13'h0003);
    cmp(ref_ratio, cur_ref[15:2]);
    cmp(ref_ratio_bad, cur_ref[15:2] == 14'h0000);
    cmp(fb_total, exp_total(cur_cfg, cur_fb));
    cmp(backlash_width, cur_ref[17:16]);
  endtask

  initial
  begin
    {nrst, ref_in, phase_ok, rdiv, ref_run, exp_lock, cur_gain} = 8'h04;
    {cur_cfg, cur_fb, cur_ref} = 72'h0;
    {seed, fails, checks_done, cycles} = {32'h4c6f, 96'h0};
    settle(4);
    cmp({pump_hiz, main_count_bad, ref_ratio_bad, fb_total}, 24'he0_0000);
    cmp(powered_down, 1'b0);
    @(posedge clk);
    nrst <= 1'b1;
    settle(2);
    for (int i = 0; i < 8; i++)
    begin
      put(corners[i], i % 2);
      check_all();
    end
    for (int i = 0; i < 16; i++)
    begin
      put(fix(24'($random(seed))), i % 3);
      check_all();
    end
    // Short ratio first, so a counter that ignores the clear bit would surely tick
    put(24'h00_0009, 0);
    put(24'h00_0010, 0);
    ticks = 0;
    repeat (60)
    begin
      settle(1);
      ticks += ref_tick;
    end
    cmp(24'(ticks), 24'h0);
    for (int s = 0; s < 2; s++)
    begin
      put(24'h00_0009 | (24'(s) << 18), 0);
      put(24'h00_0800, 0);
      wait_tick();
      @(posedge clk);
      phase_ok <= 1'b1;
      for (int i = 1; i <= 3 + 2 * s; i++)
      begin
        wait_tick();
        settle(2);
        exp_lock = (i == 3 + 2 * s);
        cmp(locked, exp_lock);
        cmp(rf_out_en, exp_lock);
      end
      @(posedge clk);
      phase_ok <= 1'b0;
      wait_tick();
      settle(2);
      exp_lock = 1'b0;
      cmp(locked, 1'b0);
    end
    put(24'h00_0000, 0);
    for (int c = 0; c < 4; c++)
    begin
      put(24'h00_0009 | (24'(c) << 20), 0);
      wait_tick();
      settle(2);
      {ticks, bands} = 64'h0;
      for (int k = 0; k < 500 && ticks < 16; k++)
      begin
        settle(1);
        ticks += ref_tick;
        bands += band_clk;
      end
      settle(1);
      bands += band_clk;
      cmp(24'(bands), 24'(16 >> c));
    end
    ref_run = 1'b0;
    put(24'h30_0000, 0);
    cmp(powered_down, 1'b0);
    ref_run = 1'b1;
    wait_tick();
    settle(2);
    cmp(powered_down, 1'b0);
    wait_tick();
    settle(2);
    cmp({powered_down, pump_hiz, counters_held, rf_out_en, locked}, 24'h1c);
    put(24'h00_0000, 0);
    check_all();
    put(24'h10_0000, 0);
    cmp({powered_down, pump_hiz, rf_out_en}, 24'h6);
    put(24'h00_0000, 0);
    check_all();
    close_out();
  end
endmodule
